// ---- rtl/pfc_pkg.sv ----
/*
 * Package for the prefetch cache control block: register offsets, field
 * positions, reset values and the packed structs that carry related signals.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package pfc_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_LINE_ACCESS = 8'h04;
    localparam logic [7:0] OFS_WORD_THREE = 8'h08;
    localparam logic [7:0] OFS_REPLACEMENT = 8'h0C;

    // Field positions inside the control register.
    localparam int POS_COHERENCY = 16;
    localparam int POS_DATA_CACHE_SIZE = 8;
    localparam int POS_PREFETCH = 4;
    localparam int POS_WAIT = 0;

    // Field positions inside the line access register.
    localparam int POS_WRITE_EN = 31;
    localparam int POS_INDEX = 0;

    // Reset values.
    localparam logic [2:0] RST_WAIT_STATES = 3'h7;
    localparam logic [1:0] RST_DATA_CACHE_SIZE = 2'h0;
    localparam logic [1:0] RST_PREFETCH = 2'h0;
    localparam logic [24:0] RST_LRU = 25'h0000000;

    // Number of cache lines and width of the line index.
    localparam int NUM_LINES = 16;
    localparam int INDEX_W = 4;

    // Control fields that steer the fetch logic.
    typedef struct packed {
        logic coherency_on_program;
        logic [1:0] data_cache_size;
        logic [1:0] predictive_prefetch_select;
        logic [2:0] flash_wait_states;
    } pfc_ctrl_s;

    // One cache line as seen by the invalidation logic.
    typedef struct packed {
        logic valid;
        logic locked;
        logic is_data;
    } pfc_line_s;

endpackage : pfc_pkg

// ---- rtl/pfc_prefetch_cache_control.sv ----
/*
 * Prefetch cache control: APB register slave, sixteen-line cache state,
 * invalidation on flash programming and on data cache size change, and a
 * flash wait-state counter for fetches.
 * Assumes a single 100 MHz clock, a synchronous active-high reset and a
 * core-side fetch port whose request is held until its acknowledge.
 */
// Chosen here: register access over APB and the placing of the registers.
//
// Summary of operation
// - Coherency set: a flash program cycle invalidates every line, locked ones too.
// - Coherency clear: program cycle invalidates data lines and unlocked instruction lines.
// - Data cache size 11/10/01 gives 4/2/1 data lines; 00 disables data caching.
// - Any change of the data cache size field invalidates all lines.
// - Prefetch field 11 both, 10 non-cacheable, 01 cacheable, 00 off.
// - Wait-state field adds zero to seven clocks per flash access; resets to seven.
// - Line writes through access registers happen only while line write enable is one.
// - The four-bit line index selects the line accessed by the word three register.
// - Word three register shows word 3 of indexed line; unreadable when code-protected.
// - Replacement state register shows 25-bit pseudo-LRU state, reset to zero.
`timescale 1ns/100ps

module pfc_prefetch_cache_control #(
    parameter int LINES = pfc_pkg::NUM_LINES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic code_protected,
    input wire logic flash_program_cycle,
    input wire logic [LINES-1:0] line_lock,
    input wire logic [LINES-1:0] line_is_data,
    input wire logic [LINES-1:0] line_fill,
    input wire logic fetch_req,
    input wire logic fetch_cacheable,
    output logic fetch_ack,
    output logic prefetch_active,
    output logic [2:0] data_lines_enabled,
    output logic [LINES-1:0] line_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.

    pfc_pkg::pfc_ctrl_s ctrl;
    logic line_write_enable;
    logic [pfc_pkg::INDEX_W-1:0] line_index;
    logic [31:0] word_three [LINES];
    logic [24:0] replacement_state;
    logic [2:0] wait_count;
    logic fetch_busy;
    logic setup_done;

    logic bus_access;
    logic bus_write;
    logic bus_read;
    logic [1:0] next_data_cache_size;
    logic size_changed;
    logic [LINES-1:0] program_kill;

    // Every access completes in its first access cycle, so pready is steady high.
    assign pready = 1'b1;
    assign bus_access = psel & penable;
    assign bus_write = bus_access & pwrite;
    assign bus_read = bus_access & ~pwrite;

    // Unmapped offsets answer with an error instead of silently vanishing.
    assign pslverr = bus_access && !(paddr == pfc_pkg::OFS_CONTROL || paddr == pfc_pkg::OFS_LINE_ACCESS
                     || paddr == pfc_pkg::OFS_WORD_THREE || paddr == pfc_pkg::OFS_REPLACEMENT);

    assign next_data_cache_size = pwdata[pfc_pkg::POS_DATA_CACHE_SIZE +: 2];
    assign size_changed = bus_write && paddr == pfc_pkg::OFS_CONTROL && next_data_cache_size != ctrl.data_cache_size;

    ////////////////////////////////////////////////////////////////////////
    // Control register. Only implemented bits are stored; the rest read zero.

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl.coherency_on_program <= 1'b0;
            ctrl.data_cache_size <= pfc_pkg::RST_DATA_CACHE_SIZE;
            ctrl.predictive_prefetch_select <= pfc_pkg::RST_PREFETCH;
            ctrl.flash_wait_states <= pfc_pkg::RST_WAIT_STATES;
        end else if (bus_write && paddr == pfc_pkg::OFS_CONTROL) begin
            ctrl.coherency_on_program <= pwdata[pfc_pkg::POS_COHERENCY];
            ctrl.data_cache_size <= next_data_cache_size;
            ctrl.predictive_prefetch_select <= pwdata[pfc_pkg::POS_PREFETCH +: 2];
            ctrl.flash_wait_states <= pwdata[pfc_pkg::POS_WAIT +: 3];
        end
    end

    // Line access register: write enable and line index.
    always_ff @(posedge clk) begin
        if (rst) begin
            line_write_enable <= 1'b0;
            line_index <= '0;
        end else if (bus_write && paddr == pfc_pkg::OFS_LINE_ACCESS) begin
            line_write_enable <= pwdata[pfc_pkg::POS_WRITE_EN];
            line_index <= pwdata[pfc_pkg::POS_INDEX +: pfc_pkg::INDEX_W];
        end
    end

    // Word three storage. Writes are dropped while the line write enable is clear,
    // which keeps stray software stores from corrupting live cache contents.
    always_ff @(posedge clk) begin
        if (bus_write && paddr == pfc_pkg::OFS_WORD_THREE && line_write_enable) begin
            word_three[line_index] <= pwdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data cache size decode.

    always_comb begin
        unique case (ctrl.data_cache_size)
            2'h3: data_lines_enabled = 3'h4;
            2'h2: data_lines_enabled = 3'h2;
            2'h1: data_lines_enabled = 3'h1;
            2'h0: data_lines_enabled = 3'h0;
        endcase
    end

    // Prefetch qualification by region type of the current fetch.
    always_comb begin
        unique case (ctrl.predictive_prefetch_select)
            2'h3: prefetch_active = fetch_req;
            2'h2: prefetch_active = fetch_req & ~fetch_cacheable;
            2'h1: prefetch_active = fetch_req & fetch_cacheable;
            2'h0: prefetch_active = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Line valid state and invalidation.

    // Locked instruction lines survive a program cycle only with coherency clear.
    always_comb begin
        for (int i = 0; i < LINES; i++) begin
            program_kill[i] = ctrl.coherency_on_program | line_is_data[i] | ~line_lock[i];
        end
    end

    // Invalidation wins over a fill in the same cycle, since the fill may hold stale flash data.
    always_ff @(posedge clk) begin
        if (rst) begin
            line_valid <= '0;
        end else if (size_changed) begin
            line_valid <= '0;
        end else if (flash_program_cycle) begin
            line_valid <= (line_valid | line_fill) & ~program_kill;
        end else begin
            line_valid <= line_valid | line_fill;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pseudo-LRU state: each fill of line i toggles state bit i mod 25.

    always_ff @(posedge clk) begin
        if (rst) begin
            replacement_state <= pfc_pkg::RST_LRU;
        end else if (size_changed) begin
            replacement_state <= pfc_pkg::RST_LRU;
        end else begin
            for (int i = 0; i < LINES; i++) begin
                if (line_fill[i]) begin
                    replacement_state[i % 25] <= ~replacement_state[i % 25];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flash access wait states: the ack comes wait_states clocks after the
    // request is seen, so zero wait states acknowledges in the first cycle.

    always_ff @(posedge clk) begin
        if (rst) begin
            fetch_busy <= 1'b0;
            wait_count <= '0;
        end else if (fetch_ack) begin
            fetch_busy <= 1'b0;
            wait_count <= '0;
        end else if (fetch_req) begin
            fetch_busy <= 1'b1;
            wait_count <= fetch_busy ? wait_count + 3'h1 : 3'h1;
        end
    end

    assign fetch_ack = fetch_req && ((fetch_busy ? wait_count : 3'h0) == ctrl.flash_wait_states);

    ////////////////////////////////////////////////////////////////////////
    // Read data mux, registered in the setup cycle so prdata comes from flops.

    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= '0;
            setup_done <= 1'b0;
        end else begin
            setup_done <= psel & ~penable;
            if (psel && !penable && !pwrite) begin
                prdata <= '0;
                unique case (paddr)
                    pfc_pkg::OFS_CONTROL: begin
                        prdata[pfc_pkg::POS_COHERENCY] <= ctrl.coherency_on_program;
                        prdata[pfc_pkg::POS_DATA_CACHE_SIZE +: 2] <= ctrl.data_cache_size;
                        prdata[pfc_pkg::POS_PREFETCH +: 2] <= ctrl.predictive_prefetch_select;
                        prdata[pfc_pkg::POS_WAIT +: 3] <= ctrl.flash_wait_states;
                    end
                    pfc_pkg::OFS_LINE_ACCESS: begin
                        prdata[pfc_pkg::POS_WRITE_EN] <= line_write_enable;
                        prdata[pfc_pkg::POS_INDEX +: pfc_pkg::INDEX_W] <= line_index;
                    end
                    pfc_pkg::OFS_WORD_THREE: begin
                        prdata <= code_protected ? 32'h00000000 : word_three[line_index];
                    end
                    pfc_pkg::OFS_REPLACEMENT: begin
                        prdata <= {7'h00, replacement_state};
                    end
                    default: begin
                        prdata <= '0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions, with two helpers: lines that must outlive a program cycle, and the word the index selects.

    logic [LINES-1:0] keep_mask;
    logic [31:0] indexed_word;
    assign keep_mask = line_valid & line_lock & ~line_is_data;
    assign indexed_word = word_three[line_index];

    property p_coh_all;
        @(posedge clk) disable iff (rst)
        (flash_program_cycle && ctrl.coherency_on_program && !size_changed) |=> (line_valid == '0);
    endproperty
    a_coh_all: assert property (p_coh_all) else $error("Program cycle left a line valid.");

    property p_locked_keep;
        @(posedge clk) disable iff (rst)
        (flash_program_cycle && !ctrl.coherency_on_program && !size_changed)
        |=> ((line_valid & $past(keep_mask)) == $past(keep_mask));
    endproperty
    a_locked_keep: assert property (p_locked_keep) else $error("Locked instruction line lost.");

    property p_program_kill;
        @(posedge clk) disable iff (rst)
        (flash_program_cycle && !ctrl.coherency_on_program && !size_changed)
        |=> ((line_valid & ($past(line_is_data) | ~$past(line_lock))) == '0);
    endproperty
    a_program_kill: assert property (p_program_kill) else $error("Unlocked line survived program.");

    property p_data_cache_size_map;
        @(posedge clk) disable iff (rst)
        (ctrl.data_cache_size == 2'h0) |-> (data_lines_enabled == 3'h0);
    endproperty
    a_data_cache_size_map: assert property (p_data_cache_size_map) else $error("Data cache not disabled.");

    property p_data_cache_size_four;
        @(posedge clk) disable iff (rst)
        (ctrl.data_cache_size == 2'h3) |-> (data_lines_enabled == 3'h4);
    endproperty
    a_data_cache_size_four: assert property (p_data_cache_size_four) else $error("Four data lines not selected.");

    property p_size_inval;
        @(posedge clk) disable iff (rst)
        size_changed |=> (line_valid == '0 && replacement_state == '0);
    endproperty
    a_size_inval: assert property (p_size_inval) else $error("Size change kept lines valid.");

    property p_pf_off;
        @(posedge clk) disable iff (rst)
        (ctrl.predictive_prefetch_select == 2'h0) |-> !prefetch_active;
    endproperty
    a_pf_off: assert property (p_pf_off) else $error("Prefetch active while disabled.");

    property p_pf_region;
        @(posedge clk) disable iff (rst)
        (fetch_req && ctrl.predictive_prefetch_select == 2'h1) |-> (prefetch_active == fetch_cacheable);
    endproperty
    a_pf_region: assert property (p_pf_region) else $error("Cacheable-only prefetch misqualified.");

    sequence s_fetch_zero_ws;
        fetch_req && !fetch_busy && ctrl.flash_wait_states == 3'h0;
    endsequence
    property p_wait_zero;
        @(posedge clk) disable iff (rst)
        s_fetch_zero_ws |-> fetch_ack;
    endproperty
    a_wait_zero: assert property (p_wait_zero) else $error("Zero wait fetch not acknowledged.");

    property p_wait_seven;
        @(posedge clk) disable iff (rst)
        (fetch_req && !fetch_busy && ctrl.flash_wait_states == 3'h7) |-> !fetch_ack;
    endproperty
    a_wait_seven: assert property (p_wait_seven) else $error("Early flash ack.");

    sequence s_fetch_one_ws;
        fetch_req && !fetch_busy && ctrl.flash_wait_states == 3'h1;
    endsequence
    property p_wait_one;
        @(posedge clk) disable iff (rst)
        s_fetch_one_ws ##1 (fetch_req && ctrl.flash_wait_states == 3'h1) |-> fetch_ack;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("One wait fetch not acknowledged.");

    property p_no_write;
        @(posedge clk) disable iff (rst)
        (bus_write && paddr == pfc_pkg::OFS_WORD_THREE && !line_write_enable)
        |=> $stable(indexed_word);
    endproperty
    a_no_write: assert property (p_no_write) else $error("Line written while disabled.");

    property p_protect;
        @(posedge clk) disable iff (rst)
        (psel && !penable && !pwrite && paddr == pfc_pkg::OFS_WORD_THREE && code_protected)
        |=> (prdata == 32'h00000000);
    endproperty
    a_protect: assert property (p_protect) else $error("Protected word readable.");

    property p_lru_top;
        @(posedge clk) disable iff (rst)
        (setup_done && paddr == pfc_pkg::OFS_REPLACEMENT && !pwrite)
        |-> (prdata[31:25] == 7'h00 && prdata[24:0] == $past(replacement_state));
    endproperty
    a_lru_top: assert property (p_lru_top) else $error("LRU upper bits not zero.");

    property p_reset_values;
        @(posedge clk)
        rst |=> (ctrl.flash_wait_states == pfc_pkg::RST_WAIT_STATES && replacement_state == pfc_pkg::RST_LRU
                 && line_valid == '0);
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("Reset values wrong.");

endmodule : pfc_prefetch_cache_control

// ---- tb/pfc_core_model.sv ----
/*
 * Core fetch model: issues one fetch at a time towards the cache and
 * measures how many cycles pass before the fetch is acknowledged.
 * Assumes fetch_ack is a one-cycle answer to a held fetch_req.
 */
`timescale 1ns/100ps
module pfc_core_model (
    input wire logic clk,
    input wire logic fetch_ack,
    input wire logic prefetch_active,
    output logic fetch_req,
    output logic fetch_cacheable
);
    initial begin
        fetch_req = 1'b0;
        fetch_cacheable = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Holds the request until the ack edge, then inverts the region line so
    // a stale value never looks like a valid qualifier.
    task automatic fetch(input logic c, output int lat, output logic pf);
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_cacheable <= c;
        lat = 0;
        @(posedge clk);
        while (fetch_ack !== 1'b1) begin
            lat++;
            @(posedge clk);
        end
        pf = prefetch_active;
        fetch_req <= 1'b0;
        fetch_cacheable <= ~c;
    endtask : fetch
endmodule : pfc_core_model

// ---- tb/tb.sv ----
/*
 * Self-checking bench for the prefetch cache control block.
 * Assumes the APB slave answers in its own time and the core model fetches.
 */
`timescale 1ns/100ps
module tb;
    logic clk, rst, psel, penable, pwrite, code_protected, flash_program_cycle;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, fetch_req, fetch_cacheable, fetch_ack, prefetch_active;
    logic [2:0] data_lines_enabled;
    logic [15:0] line_lock, line_is_data, line_fill, line_valid;
    int mismatches = 0;
    int n_checks = 0;

    pfc_prefetch_cache_control pfc_prefetch_cache_control_i (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .code_protected(code_protected),
        .flash_program_cycle(flash_program_cycle), .line_lock(line_lock), .line_is_data(line_is_data),
        .line_fill(line_fill), .fetch_req(fetch_req), .fetch_cacheable(fetch_cacheable),
        .fetch_ack(fetch_ack), .prefetch_active(prefetch_active),
        .data_lines_enabled(data_lines_enabled), .line_valid(line_valid));
    pfc_core_model pfc_core_model_i (.clk(clk), .fetch_ack(fetch_ack), .prefetch_active(prefetch_active),
        .fetch_req(fetch_req), .fetch_cacheable(fetch_cacheable));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Watchdog sized well above the expected run of a few hundred cycles.
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and bus helpers.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // One APB transfer; the request holds until pready is seen at an edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Wait states are the slave's choice; only the watchdog ends this wait.
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Control write with every unimplemented bit left at zero.
    task automatic ctrl(input logic coh, input logic [1:0] sz, input logic [1:0] pf, input logic [2:0] ws);
        apb(1'b1, pfc_pkg::OFS_CONTROL, 32'(coh) << pfc_pkg::POS_COHERENCY | 32'(sz) << pfc_pkg::POS_DATA_CACHE_SIZE
            | 32'(pf) << pfc_pkg::POS_PREFETCH | 32'(ws));
        @(posedge clk);
    endtask : ctrl

    // One-cycle pulse of program cycle and line fills, then let it land.
    task automatic pulse(input logic prog, input logic [15:0] fill);
        @(posedge clk);
        flash_program_cycle <= prog;
        line_fill <= fill;
        @(posedge clk);
        flash_program_cycle <= 1'b0;
        line_fill <= 16'h0000;
        @(posedge clk);
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_reset();
        apb(1'b0, pfc_pkg::OFS_CONTROL, 32'h00000000);
        chk("control reset", rd, 32'h00000007);
        apb(1'b0, pfc_pkg::OFS_REPLACEMENT, 32'h00000000);
        chk("lru reset", rd, 32'h00000000);
        chk("lines reset", 32'(line_valid), 32'h00000000);
    endtask : t_reset

    // Same size keeps lines; every real change clears them and the state.
    task automatic t_size();
        logic [2:0] n [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        for (int s = 0; s < 4; s++) begin
            pulse(1'b0, 16'hFFFF);
            ctrl(1'b0, 2'(s), 2'h0, 3'h7);
            chk("valid after size", 32'(line_valid), (s == 0) ? 32'h0000FFFF : 32'h00000000);
            chk("data lines", 32'(data_lines_enabled), 32'(n[s]));
        end
        pulse(1'b0, 16'h0003);
        apb(1'b1, pfc_pkg::OFS_REPLACEMENT, 32'h01FFFFFF);
        apb(1'b0, pfc_pkg::OFS_REPLACEMENT, 32'h00000000);
        chk("lru after fill", rd, 32'h00000003);
    endtask : t_size

    // Each wait-state count once; together they cover each prefetch code with each region kind.
    task automatic t_fetch();
        int lat;
        logic pf;
        for (int i = 0; i < 8; i++) begin
            ctrl(1'b0, 2'h3, 2'(i), 3'(i));
            pfc_core_model_i.fetch(i[2], lat, pf);
            chk("fetch latency", 32'(lat), 32'(i));
            chk("prefetch", 32'(pf), 32'((i[1] & ~i[2]) | (i[0] & i[2])));
        end
    endtask : t_fetch

    task automatic t_program();
        line_lock <= 16'h00FF;
        line_is_data <= 16'h0F0F;
        ctrl(1'b1, 2'h3, 2'h0, 3'h0);
        pulse(1'b0, 16'hFFFF);
        pulse(1'b1, 16'h0000);
        chk("program coherent", 32'(line_valid), 32'h00000000);
        ctrl(1'b0, 2'h3, 2'h0, 3'h0);
        pulse(1'b0, 16'hFFFF);
        pulse(1'b1, 16'h0000);
        chk("program locked kept", 32'(line_valid), 32'h000000F0);
    endtask : t_program

    task automatic t_lines();
        apb(1'b1, pfc_pkg::OFS_LINE_ACCESS, 32'h80000005);
        apb(1'b1, pfc_pkg::OFS_WORD_THREE, 32'h5A5A0005);
        apb(1'b1, pfc_pkg::OFS_LINE_ACCESS, 32'h80000006);
        apb(1'b1, pfc_pkg::OFS_WORD_THREE, 32'hA5A50006);
        apb(1'b1, pfc_pkg::OFS_LINE_ACCESS, 32'h00000005);
        apb(1'b1, pfc_pkg::OFS_WORD_THREE, 32'hFFFFFFFF);
        apb(1'b0, pfc_pkg::OFS_LINE_ACCESS, 32'h00000000);
        chk("access reg", rd, 32'h00000005);
        apb(1'b0, pfc_pkg::OFS_WORD_THREE, 32'h00000000);
        chk("word three 5", rd, 32'h5A5A0005);
        apb(1'b1, pfc_pkg::OFS_LINE_ACCESS, 32'h00000006);
        apb(1'b0, pfc_pkg::OFS_WORD_THREE, 32'h00000000);
        chk("word three 6", rd, 32'hA5A50006);
        code_protected <= 1'b1;
        apb(1'b0, pfc_pkg::OFS_WORD_THREE, 32'h00000000);
        chk("protected read", rd, 32'h00000000);
        code_protected <= 1'b0;
        apb(1'b0, 8'h10, 32'h00000000);
        chk("unmapped error", 32'(err), 32'h00000001);
        chk("unmapped data", rd, 32'h00000000);
    endtask : t_lines

    // A reset in mid-run must bring back the power-up values after real activity.
    task automatic t_rerun();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
    endtask : t_rerun

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: inputs at time zero, four cycles of reset, then tests.
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, code_protected, flash_program_cycle} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        line_lock = 16'h0000;
        line_is_data = 16'h0000;
        line_fill = 16'h0000;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_size();
        t_fetch();
        t_program();
        t_lines();
        t_rerun();
        stop_test();
    end
endmodule : tb
